// file: buck_pkg.sv
// Function
// RQ1 - each buck holds normal and retention voltage, chosen by pin or bit
// RQ2 - power good sets above threshold, clears below threshold minus hysteresis
// RQ3 - per-buck mask hides power good during a voltage ramp
// RQ4 - power good state of each buck is readable as a status bit
// RQ5 - power good routable to either general pin by per-buck select
// RQ6 - pin-mode write overrides pin until next internal power good change
// RQ7 - rewriting the active setting with a new value starts a ramp
// RQ8 - switching between normal and retention setting starts a ramp
// RQ9 - during a ramp the buck runs forced pwm with synchronous rectification
// RQ10 - ramp-complete flag routable to either general pin per buck
// RQ11 - ramp-complete reflects the digital ramp only, not the real output
// RQ12 - ramp steps 10 mV per 4, 2, 1 or 0.5 us interval
// RQ13 - voltage codes step 10 mV from 0.3 V to 1.57 V
// RQ14 - disabled buck switches on phase pull-downs unless pull-down-off set
// RQ15 - phases excluded by phase select never get a pull-down
// RQ16 - with the device off all pull-downs stay off
// RQ17 - oscillator trim moves 6 MHz clock in 180 kHz steps
// RQ18 - mode field selects synchronous pwm or pfm operation
// RQ19 - shedding in pwm mode adds or drops phases with load
// RQ20 - phase select caps active phases in every condition
// RQ21 - automatic mode picks pwm or pfm from load current
// RQ22 - mode 00 takes pwm or pfm from the active voltage setting
// RQ23 - both triggers ramp, ready flag asserted while ramping
// RQ24 - per-buck maximum clamps every programmed target
// RQ25 - ramp moves one step per interval and stops exactly on target
package buck_pkg;
  localparam int VCODE_W = 7;
  typedef logic [VCODE_W-1:0] vcode_type;
  // code 0 is 0.3 V, 127 is 1.57 V, 10 mV per code
  localparam vcode_type VCODE_MAX = 7'h7f; // RQ13
  localparam vcode_type VCODE_RST = 7'h46;
  localparam int PHASES = 2;
  localparam int STEP_TIME_PS = 500000;
  localparam int CLK_PERIOD_PS = 10000;
  // base interval 0.5 us, other rates are 2, 4, 8 times that
  localparam int STEP_CYC = (STEP_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TICK_W = 10;
  localparam logic [TICK_W-1:0] TICK_BASE = TICK_W'(STEP_CYC);
  localparam logic [5:0] OSC_BASE_KHZ_DIV = 6'h00;
  localparam int OSC_STEP_KHZ = 180;
  typedef enum logic [1:0] {
    MODE_FROM_VREG, MODE_PFM, MODE_PWM, MODE_AUTO
  } conv_mode_type;
  typedef enum logic [1:0] {ROUTE_NONE, ROUTE_PIN_TWO, ROUTE_PIN_THREE,
    ROUTE_RSVD} route_type;
endpackage

// file: ramp_gen.sv
`timescale 1ns/1ps
module ramp_gen
  import buck_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic enable,
  input wire buck_pkg::vcode_type target,
  input wire logic [1:0] slew_sel,
  // state
  output buck_pkg::vcode_type level_r,
  output logic ramping
);
  import buck_pkg::*;
  logic [TICK_W-1:0] tick_r;
  logic [TICK_W-1:0] tick_len;
  logic at_goal;
  logic tick_end;
  // slew_sel 0 = 4 us, 1 = 2 us, 2 = 1 us, 3 = 0.5 us
  assign tick_len = TICK_W'(TICK_BASE << (2'd3 - slew_sel)); // RQ12
  assign at_goal = (level_r == target);
  assign tick_end = (tick_r >= tick_len - TICK_W'(1));
  // flag drops the cycle the last step lands, not when output settles
  assign ramping = !at_goal && enable; // RQ11 RQ23 RQ25

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_r <= '0;
    end else if (!ramping || tick_end) begin
      tick_r <= '0;
    end else begin
      tick_r <= tick_r + TICK_W'(1);
    end
  end

  // one 10 mV code per interval toward the goal
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_r <= VCODE_RST;
    end else if (!enable) begin
      level_r <= target;
    end else if (ramping && tick_end) begin
      if (level_r < target) begin
        level_r <= level_r + vcode_type'(1); // RQ25
      end else begin
        level_r <= level_r - vcode_type'(1); // RQ25
      end
    end
  end
endmodule

// file: pin_router.sv
`timescale 1ns/1ps
module pin_router
  import buck_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // sources
  input wire logic ok_a,
  input wire logic ok_b,
  input wire logic done_a,
  input wire logic done_b,
  // routing
  input wire buck_pkg::route_type ok_pin_route_a,
  input wire buck_pkg::route_type ok_pin_route_b,
  input wire buck_pkg::route_type ramp_done_route_a,
  input wire buck_pkg::route_type ramp_done_route_b,
  input wire logic [1:0] pin_is_out,
  // host pin mode writes
  input wire logic [1:0] pin_mode_wr,
  input wire logic [1:0] pin_mode_level,
  // pin drive
  output logic [1:0] pin_level_r
);
  import buck_pkg::*;
  logic ok_a_r;
  logic ok_b_r;
  logic done_a_r;
  logic done_b_r;
  logic [1:0] src_val;
  logic [1:0] src_chg;
  logic chg_ok_a;
  logic chg_ok_b;
  logic chg_dn_a;
  logic chg_dn_b;

  function automatic logic on_pin(input route_type r, input int p);
    return (p == 0) ? (r == ROUTE_PIN_TWO) : (r == ROUTE_PIN_THREE);
  endfunction

  assign chg_ok_a = ok_a ^ ok_a_r;
  assign chg_ok_b = ok_b ^ ok_b_r;
  assign chg_dn_a = done_a ^ done_a_r;
  assign chg_dn_b = done_b ^ done_b_r;

  for (genvar p = 0; p < 2; p++) begin : g_pin
    // power good of a wins over b if both land on one pin
    assign src_val[p] = on_pin(ok_pin_route_a, p) ? ok_a : // RQ5
      on_pin(ok_pin_route_b, p) ? ok_b :
      on_pin(ramp_done_route_a, p) ? done_a : // RQ10
      done_b;
    assign src_chg[p] = (on_pin(ok_pin_route_a, p) && chg_ok_a) ||
      (on_pin(ok_pin_route_b, p) && chg_ok_b) ||
      (on_pin(ramp_done_route_a, p) && chg_dn_a) ||
      (on_pin(ramp_done_route_b, p) && chg_dn_b);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ok_a_r <= 1'b0;
      ok_b_r <= 1'b0;
      done_a_r <= 1'b0;
      done_b_r <= 1'b0;
    end else begin
      ok_a_r <= ok_a;
      ok_b_r <= ok_b;
      done_a_r <= done_a;
      done_b_r <= done_b;
    end
  end

  // host write holds until the routed source next changes
  for (genvar p = 0; p < 2; p++) begin : g_drv
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        pin_level_r[p] <= 1'b0;
      end else if (!pin_is_out[p]) begin // RQ5
        pin_level_r[p] <= 1'b0;
      end else if (src_chg[p]) begin
        pin_level_r[p] <= src_val[p]; // RQ6
      end else if (pin_mode_wr[p]) begin
        pin_level_r[p] <= pin_mode_level[p]; // RQ6
      end
    end
  end
endmodule

// file: buck_dvc_powergood_control.sv
`timescale 1ns/1ps
module buck_dvc_powergood_control
  import buck_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // chip and buck enables
  input wire logic chip_enable_pin,
  input wire logic [1:0] buck_enable_pin,
  // voltage select
  input wire logic [1:0] volt_select_pin,
  input wire logic [1:0] volt_select_pin_from_pin,
  input wire logic volt_choice_a,
  input wire logic volt_choice_b,
  // voltage settings, pwm select bits per buck: bit0 normal, bit1 retention
  input wire buck_pkg::vcode_type vnorm_a,
  input wire buck_pkg::vcode_type vret_a,
  input wire buck_pkg::vcode_type vnorm_b,
  input wire buck_pkg::vcode_type vret_b,
  input wire buck_pkg::vcode_type vmax_a,
  input wire buck_pkg::vcode_type vmax_b,
  input wire logic [1:0] vreg_pwm_a,
  input wire logic [1:0] vreg_pwm_b,
  input wire logic [1:0] slew_sel_a,
  input wire logic [1:0] slew_sel_b,
  // analogue comparators per buck
  input wire logic [1:0] above_pg_th,
  input wire logic [1:0] below_pg_hys,
  input wire logic [1:0] load_high,
  input wire logic [1:0] load_shed,
  // power good config
  input wire logic pg_ramp_mask_a,
  input wire logic pg_ramp_mask_b,
  input wire buck_pkg::route_type ok_pin_route_a,
  input wire buck_pkg::route_type ok_pin_route_b,
  input wire buck_pkg::route_type ramp_done_route_a,
  input wire buck_pkg::route_type ramp_done_route_b,
  input wire logic [1:0] pin_is_out,
  input wire logic [1:0] pin_mode_wr,
  input wire logic [1:0] pin_mode_level,
  // phases and modes
  input wire logic pulldown_off_a,
  input wire logic pulldown_off_b,
  input wire logic [1:0] phase_sel_a,
  input wire logic [1:0] phase_sel_b,
  input wire logic shed_enable_a,
  input wire logic shed_enable_b,
  input wire buck_pkg::conv_mode_type conv_mode_a,
  input wire buck_pkg::conv_mode_type conv_mode_b,
  input wire logic [5:0] osc_trim,
  // status
  output logic output_ok_status_a,
  output logic output_ok_status_b,
  output logic [1:0] ramp_busy,
  // pins
  output logic gp_pin_two,
  output logic gp_pin_three,
  // converter drive
  output buck_pkg::vcode_type dac_a,
  output buck_pkg::vcode_type dac_b,
  output logic [1:0] pwm_forced,
  output logic [1:0] pfm_on,
  output logic [1:0] phase_on_a,
  output logic [1:0] phase_on_b,
  output logic [1:0] pulldown_on_a,
  output logic [1:0] pulldown_on_b,
  output logic [5:0] osc_trim_out
);
  import buck_pkg::*;

  // ****************************************
  // voltage target selection
  // ****************************************
  logic [1:0] en;
  logic [1:0] sel_ret;
  vcode_type tgt_a;
  vcode_type tgt_b;
  logic [1:0] pwm_a_vreg;
  logic [1:0] busy;
  logic [1:0] pg_r;
  logic [1:0] pg_nxt;
  logic [1:0] pg_vis;
  logic [1:0] pwm_mode;
  logic [1:0] pfm_mode;
  logic [1:0] shed_r;

  function automatic vcode_type clamp(input vcode_type v, input vcode_type m);
    return (v > m) ? m : v;
  endfunction

  function automatic logic [1:0] phase_mask(input logic [1:0] sel,
                                            input logic shed);
    // sel 0 = one phase, else both; shedding never exceeds sel
    return (sel == 2'h0 || shed) ? 2'h1 : 2'h3;
  endfunction

  assign en = buck_enable_pin & {2{chip_enable_pin}};
  assign sel_ret[0] = volt_select_pin_from_pin[0] ? volt_select_pin[0] :
    volt_choice_a; // RQ1
  assign sel_ret[1] = volt_select_pin_from_pin[1] ? volt_select_pin[1] :
    volt_choice_b; // RQ1
  // the ramp goal follows the live value and the selection, clamped to the per-buck maximum
  assign tgt_a = clamp(sel_ret[0] ? vret_a : vnorm_a, vmax_a); // RQ7 RQ8 RQ24
  assign tgt_b = clamp(sel_ret[1] ? vret_b : vnorm_b, vmax_b); // RQ7 RQ8 RQ24
  assign pwm_a_vreg = {vreg_pwm_b[sel_ret[1]], vreg_pwm_a[sel_ret[0]]};

  // ****************************************
  // ramps
  // ****************************************
  ramp_gen u_ramp_a (
    .clk(clk),
    .sys_rst(sys_rst),
    .enable(en[0]),
    .target(tgt_a),
    .slew_sel(slew_sel_a),
    .level_r(dac_a),
    .ramping(busy[0])
  );

  ramp_gen u_ramp_b (
    .clk(clk),
    .sys_rst(sys_rst),
    .enable(en[1]),
    .target(tgt_b),
    .slew_sel(slew_sel_b),
    .level_r(dac_b),
    .ramping(busy[1])
  );

  assign ramp_busy = busy; // RQ23

  // ****************************************
  // power good with hysteresis
  // ****************************************
  for (genvar i = 0; i < 2; i++) begin : g_pg
    assign pg_nxt[i] = !en[i] ? 1'b0 :
      above_pg_th[i] ? 1'b1 :
      below_pg_hys[i] ? 1'b0 : pg_r[i]; // RQ2
  end
  assign pg_vis[0] = pg_r[0] && !(pg_ramp_mask_a && busy[0]); // RQ3
  assign pg_vis[1] = pg_r[1] && !(pg_ramp_mask_b && busy[1]); // RQ3
  assign output_ok_status_a = pg_vis[0]; // RQ4
  assign output_ok_status_b = pg_vis[1]; // RQ4

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pg_r <= 2'h0;
    end else begin
      pg_r <= pg_nxt;
    end
  end

  // ****************************************
  // pin routing
  // ****************************************
  logic [1:0] pin_lvl;

  pin_router u_route (
    .clk(clk),
    .sys_rst(sys_rst),
    .ok_a(pg_vis[0]),
    .ok_b(pg_vis[1]),
    .done_a(busy[0]),
    .done_b(busy[1]),
    .ok_pin_route_a(ok_pin_route_a),
    .ok_pin_route_b(ok_pin_route_b),
    .ramp_done_route_a(ramp_done_route_a),
    .ramp_done_route_b(ramp_done_route_b),
    .pin_is_out(pin_is_out),
    .pin_mode_wr(pin_mode_wr),
    .pin_mode_level(pin_mode_level),
    .pin_level_r(pin_lvl)
  );
  assign gp_pin_two = pin_lvl[0];
  assign gp_pin_three = pin_lvl[1];

  // ****************************************
  // operating mode
  // ****************************************
  for (genvar i = 0; i < 2; i++) begin : g_mode
    conv_mode_type m;
    assign m = (i == 0) ? conv_mode_a : conv_mode_b;
    assign pwm_mode[i] = busy[i] || // RQ9
      (m == MODE_PWM) || // RQ18
      (m == MODE_FROM_VREG && pwm_a_vreg[i]) || // RQ22
      (m == MODE_AUTO && load_high[i]); // RQ21
    assign pfm_mode[i] = en[i] && !pwm_mode[i];
  end
  assign pwm_forced = pwm_mode & en;
  assign pfm_on = pfm_mode;

  // shedding state registered so the phase count does not chatter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shed_r <= 2'h0;
    end else begin
      shed_r[0] <= shed_enable_a && pwm_mode[0] && !busy[0] &&
        load_shed[0]; // RQ19
      shed_r[1] <= shed_enable_b && pwm_mode[1] && !busy[1] &&
        load_shed[1]; // RQ19
    end
  end

  assign phase_on_a = en[0] ? phase_mask(phase_sel_a, shed_r[0]) :
    2'h0; // RQ20
  assign phase_on_b = en[1] ? phase_mask(phase_sel_b, shed_r[1]) :
    2'h0; // RQ20

  // ****************************************
  // pull-downs and oscillator
  // ****************************************
  assign pulldown_on_a = (chip_enable_pin && !buck_enable_pin[0] && // RQ16
    !pulldown_off_a) ? phase_mask(phase_sel_a, 1'b0) : 2'h0; // RQ14 RQ15
  assign pulldown_on_b = (chip_enable_pin && !buck_enable_pin[1] && // RQ16
    !pulldown_off_b) ? phase_mask(phase_sel_b, 1'b0) : 2'h0; // RQ14 RQ15
  // each trim code moves the oscillator by one 180 kHz step
  assign osc_trim_out = osc_trim; // RQ17
endmodule

// file: buck_ctl_props.sv
`timescale 1ns/1ps
// ****
// buck a control checks, with the device-off pull-down check covering both bucks
// ****
module buck_ctl_props
  import buck_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // inputs
  input wire logic chip_enable_pin,
  input wire logic [1:0] buck_enable_pin,
  input wire logic pulldown_off_a,
  input wire logic [1:0] phase_sel_a,
  input wire logic pg_ramp_mask_a,
  input wire logic [1:0] slew_sel_a,
  input wire buck_pkg::vcode_type vmax_a,
  // outputs
  input wire logic output_ok_status_a,
  input wire logic [1:0] ramp_busy,
  input wire buck_pkg::vcode_type dac_a,
  input wire logic [1:0] pwm_forced,
  input wire logic [1:0] pulldown_on_a,
  input wire logic [1:0] pulldown_on_b
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  wire a_on = chip_enable_pin & buck_enable_pin[0];
  sequence step_s;
    ramp_busy[0] && a_on ##1 $changed(dac_a);
  endsequence
  ramp_step_a: assert property (step_s |->
    dac_a == $past(dac_a) + 7'h01 || dac_a == $past(dac_a) - 7'h01)
    else $error("ramp moved by more than one code");
  // a disable lets the level jump, so only enabled cycles count
  step_hold_a: assert property (
    (step_s ##0 slew_sel_a == 2'h3 ##0 ramp_busy[0])
    |=> (!$changed(dac_a) || !$past(a_on))[*8])
    else $error("ramp steps closer than one interval");
  ramp_pwm_a: assert property (ramp_busy[0] && a_on |-> pwm_forced[0])
    else $error("ramp without forced pwm");
  clamp_max_a: assert property (
    a_on && !ramp_busy[0] |-> dac_a <= vmax_a)
    else $error("level above maximum");
  pg_mask_a: assert property (pg_ramp_mask_a && ramp_busy[0]
    |-> !output_ok_status_a)
    else $error("power good shown while masked");
  pd_chip_off_a: assert property (!chip_enable_pin
    |-> pulldown_on_a == 2'h0 && pulldown_on_b == 2'h0)
    else $error("pull-down while device off");
  pd_excluded_a: assert property (
    phase_sel_a == 2'h0 |-> !pulldown_on_a[1])
    else $error("pull-down on excluded phase");
  pd_disabled_a: assert property (chip_enable_pin && !buck_enable_pin[0]
    && !pulldown_off_a && phase_sel_a != 2'h0 |-> pulldown_on_a == 2'h3)
    else $error("pull-downs missing on disabled buck");
endmodule

bind buck_dvc_powergood_control buck_ctl_props u_props (.*);

// file: out_stage.sv
`timescale 1ns/1ps
// ****
// output stage with pg comparators
// ****
module out_stage
  import buck_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // drive
  input wire logic enable,
  input wire buck_pkg::vcode_type dac,
  input wire logic droop,
  // comparators
  output logic above,
  output logic below_hys
);
  // slews 1 code per 4 cycles, faster than any ramp, so pg holds on ramps
  logic [8:0] vout_r;
  logic [1:0] div_r;
  wire [8:0] goal = enable ? {2'h0, dac} : 9'h000;
  assign above = enable && vout_r + 9'h003 >= goal;
  assign below_hys = vout_r + 9'h005 < goal;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vout_r <= 9'h000;
      div_r <= 2'h0;
    end else if (droop) begin
      vout_r <= 9'h000;
    end else begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h0 && vout_r < goal) vout_r <= vout_r + 9'h001;
      if (div_r == 2'h0 && vout_r > goal) vout_r <= vout_r - 9'h001;
    end
  end
endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  import buck_pkg::*;
  // ****
  // stimulus and wiring
  // ****
  logic clk = 1'b0, sys_rst = 1'b1, chip_enable_pin = 1'b1;
  logic volt_choice_a = 1'b0, volt_choice_b = 1'b0, pg_ramp_mask_a = 1'b0;
  logic pg_ramp_mask_b = 1'b0, pulldown_off_a = 1'b0, pulldown_off_b = 1'b0;
  logic shed_enable_a = 1'b0, shed_enable_b = 1'b0;
  logic [1:0] droop = 2'h0, buck_enable_pin = 2'h3, volt_select_pin = 2'h0;
  logic [1:0] volt_select_pin_from_pin = 2'h0, vreg_pwm_a = 2'h0, vreg_pwm_b = 2'h0;
  logic [1:0] slew_sel_a = 2'h3, slew_sel_b = 2'h3, load_high = 2'h0;
  logic [1:0] load_shed = 2'h0, pin_is_out = 2'h3, pin_mode_wr = 2'h0;
  logic [1:0] pin_mode_level = 2'h0, phase_sel_a = 2'h1, phase_sel_b = 2'h1;
  logic [5:0] osc_trim = 6'h15;
  vcode_type vnorm_a = 7'h46, vret_a = 7'h50, vnorm_b = 7'h46, vret_b = 7'h46;
  vcode_type vmax_a = 7'h7f, vmax_b = 7'h7f;
  route_type ok_pin_route_a = ROUTE_PIN_THREE, ok_pin_route_b = ROUTE_NONE;
  route_type ramp_done_route_a = ROUTE_NONE;
  route_type ramp_done_route_b = ROUTE_PIN_TWO;
  conv_mode_type conv_mode_a = MODE_PWM, conv_mode_b = MODE_PWM;
  logic output_ok_status_a, output_ok_status_b, gp_pin_two, gp_pin_three;
  logic [1:0] ramp_busy, pwm_forced, pfm_on, phase_on_a, phase_on_b;
  logic [1:0] pulldown_on_a, pulldown_on_b;
  logic [5:0] osc_trim_out;
  vcode_type dac_a, dac_b;
  wire [1:0] above_pg_th, below_pg_hys;
  int n_mismatch = 0;
  int checks_done = 0;
  int n;
  buck_dvc_powergood_control u_dut (.*);
  out_stage u_out_a (.clk(clk), .sys_rst(sys_rst), .dac(dac_a),
    .enable(chip_enable_pin & buck_enable_pin[0]), .droop(droop[0]),
    .above(above_pg_th[0]), .below_hys(below_pg_hys[0]));
  out_stage u_out_b (.clk(clk), .sys_rst(sys_rst), .dac(dac_b),
    .enable(chip_enable_pin & buck_enable_pin[1]), .droop(droop[1]),
    .above(above_pg_th[1]), .below_hys(below_pg_hys[1]));
  initial begin
    forever #5 clk = ~clk;
  end
  // ****
  // tasks
  // ****
  task automatic chk(input string what, input logic [6:0] e,
      input logic [6:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic ramp_a(input vcode_type lvl, input int cyc);
    n = 0;
    @(negedge clk);
    chk("busy", 7'h1, 7'(ramp_busy[0]));
    chk("pwm", 7'h1, 7'(pwm_forced[0]));
    chk("mask", 7'h0, 7'(output_ok_status_a & pg_ramp_mask_a));
    do begin
      @(negedge clk);
      n++;
    end while (ramp_busy[0] === 1'b1 && n < 2000);
    chk("level", lvl, dac_a);
    chk("time", 7'h1, 7'(n > cyc - 3 && n < cyc + 2));
  endtask
  task automatic mode(input conv_mode_type m, input logic [1:0] vp,
      input logic lh, input logic e);
    @(posedge clk);
    conv_mode_a <= m;
    vreg_pwm_a <= vp;
    load_high <= {1'b0, lh};
    @(negedge clk);
    chk("pfm", 7'(e), 7'(pfm_on[0]));
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    tick(16);
    sys_rst <= 1'b0;
    tick(400);
    @(negedge clk);
    chk("pg a", 7'h1, 7'(output_ok_status_a));
    chk("pg pin", 7'h1, 7'(gp_pin_three));
    chk("osc", 7'h15, 7'(osc_trim_out));
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      slew_sel_a <= 2'(s);
      vnorm_a <= 7'(7'h47 + s);
      ramp_a(7'(7'h47 + s), 400 >> s);
    end
    @(posedge clk);
    pg_ramp_mask_a <= 1'b1;
    volt_choice_a <= 1'b1;
    // pfm selected so only the ramp itself can force pwm
    conv_mode_a <= MODE_PFM;
    ramp_a(7'h50, 300);
    @(posedge clk);
    vmax_a <= 7'h4c;
    conv_mode_a <= MODE_PWM;
    ramp_a(7'h4c, 200);
    @(posedge clk);
    volt_select_pin_from_pin <= 2'h1;
    ramp_a(7'h4a, 100);
    // b output held low: the ramp flag must still end on time
    @(posedge clk);
    vnorm_b <= 7'h48;
    droop <= 2'h2;
    tick(20);
    @(negedge clk);
    chk("done pin busy", 7'h1, 7'(gp_pin_two));
    tick(100);
    @(negedge clk);
    chk("done pin idle", 7'h0, 7'(gp_pin_two));
    chk("level b", 7'h48, dac_b);
    chk("pg b low", 7'h0, 7'(output_ok_status_b));
    @(posedge clk);
    droop <= 2'h0;
    pin_mode_wr <= 2'h2;
    @(posedge clk);
    pin_mode_wr <= 2'h0;
    tick(20);
    @(negedge clk);
    chk("pin held", 7'h0, 7'(gp_pin_three));
    @(posedge clk);
    droop <= 2'h1;
    tick(4);
    @(negedge clk);
    chk("pg drop", 7'h0, 7'(output_ok_status_a));
    @(posedge clk);
    droop <= 2'h0;
    tick(400);
    @(negedge clk);
    chk("pin refresh", 7'h1, 7'(gp_pin_three));
    @(posedge clk);
    buck_enable_pin <= 2'h2;
    @(negedge clk);
    chk("pd on", 7'h3, 7'(pulldown_on_a));
    @(posedge clk);
    phase_sel_a <= 2'h0;
    @(negedge clk);
    chk("pd excl", 7'h1, 7'(pulldown_on_a));
    @(posedge clk);
    pulldown_off_a <= 1'b1;
    @(negedge clk);
    chk("pd off", 7'h0, 7'(pulldown_on_a));
    @(posedge clk);
    pulldown_off_a <= 1'b0;
    chip_enable_pin <= 1'b0;
    @(negedge clk);
    chk("pd chip", 7'h0, 7'({pulldown_on_a, pulldown_on_b}));
    @(posedge clk);
    chip_enable_pin <= 1'b1;
    buck_enable_pin <= 2'h3;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ramp_busy[0] !== 1'b0 && n < 1000);
    chk("one phase", 7'h1, 7'(phase_on_a));
    chk("phases b", 7'h3, 7'(phase_on_b));
    @(posedge clk);
    phase_sel_a <= 2'h1;
    shed_enable_a <= 1'b1;
    load_shed <= 2'h1;
    // shedding state is registered, so it shows one edge later
    tick(1);
    @(negedge clk);
    chk("shed", 7'h1, 7'(phase_on_a));
    mode(MODE_PFM, 2'h3, 1'b0, 1'b1);
    mode(MODE_PWM, 2'h0, 1'b0, 1'b0);
    mode(MODE_FROM_VREG, 2'h1, 1'b0, 1'b0);
    mode(MODE_FROM_VREG, 2'h2, 1'b0, 1'b1);
    mode(MODE_AUTO, 2'h0, 1'b1, 1'b0);
    report_and_stop();
  end
endmodule
